// ### pcf_pkg.sv
// Constants for the front of a function's configuration header: offsets,
// field positions, reset values and fixed codes.
// Assumes configuration accesses arrive as word-aligned dword cycles.
// Operation
// - Read-only maker identification at offset 00h.
// - Read-only part identification at offset 02h.
// - Command bit 10 blocks the interrupt line.
// - Bit 10 reads zero without revision features.
// - Command bit 9 always reads zero.
// - System error driver enabled by bit 8.
// - Parity error driving enabled by bit 6.
// - Command bit 5 always reads zero.
// - Write-invalidate only while bit 4 set.
// - Bit 3 zero, special cycles ignored.
// - Bus mastering only while bit 2 set.
// - Memory cycles claimed only while bit 1.
// - Bit 0 zero, no I/O claims.
// - Reserved command bits zero, all reset zero.
// - Status word at 06h resets to 0210h.
// - Interrupt needs status bit 3, no disable.
// - Status bits 10:9 fixed at 01b.
// - Master abort sets status bit 13.
package pcf_pkg;
  // Dword index of the two implemented configuration words.
  localparam logic [5:0] PCF_DW_IDENT = 6'h00;
  localparam logic [5:0] PCF_DW_CMDSTAT = 6'h01;
  // Arbitrary identification codes, not those of any real maker.
  localparam logic [15:0] PCF_MAKER_IDENT = 16'h1234;
  localparam logic [15:0] PCF_PART_IDENT = 16'h5678;
  // Command field positions.
  localparam int PCF_CMD_IO = 0;
  localparam int PCF_CMD_MEM = 1;
  localparam int PCF_CMD_MASTER = 2;
  localparam int PCF_CMD_MWI = 4;
  localparam int PCF_CMD_PERR = 6;
  localparam int PCF_CMD_SERR = 8;
  localparam int PCF_CMD_INTDIS = 10;
  // Writable command bits besides bit 10; everything else reads zero.
  localparam logic [15:0] PCF_CMD_WMASK = 16'h0156;
  localparam logic [15:0] PCF_CMD_RESET = 16'h0000;
  // Status field positions.
  localparam int PCF_ST_INT = 3;
  localparam int PCF_ST_DATAPAR = 8;
  localparam int PCF_ST_TABORT_SIG = 11;
  localparam int PCF_ST_TABORT_REC = 12;
  localparam int PCF_ST_MASTER_ABORT_SEEN = 13;
  localparam int PCF_ST_SYSERR = 14;
  localparam int PCF_ST_PARERR = 15;
  // Fixed status bits: medium decode timing and capability list.
  localparam logic [15:0] PCF_ST_FIXED = 16'h0210;
  localparam logic [15:0] PCF_ST_RESET = 16'h0210;
  // Event bits cleared by writing one.
  localparam logic [15:0] PCF_ST_W1C = 16'hf900;
endpackage : pcf_pkg

// ### pcf_sticky_bit.sv
// One sticky event flag: hardware sets, software clears by writing one.
// Assumes a single clock with enable and asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pcf_sticky_bit (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Set and clear requests.
  input wire logic set_i,
  input wire logic clr_i,
  // Flag value.
  output logic flag_o
);
  logic flag_q;
  logic flag_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    flag_d = flag_q;
    if (set_i) begin
      flag_d = 1'b1;
    end else if (clr_i) begin
      flag_d = 1'b0;
    end
  end

  // Registers the flag; frozen while the clock enable is low.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
    end else if (clk_en_i) begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

  // A set request with the clock enable high leaves the flag high, whatever the clear does.
  property p_set_wins;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && set_i |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Set lost against clear.");
endmodule : pcf_sticky_bit
`default_nettype wire

// ### pcf_config_front.sv
// Configuration header front: identification, command and status words.
// Assumes the bus front end presents decoded configuration reads and
// writes with byte enables, and reports bus events as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module pcf_config_front (
  // Clock, reset and clock enable.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Configuration access port, one dword per access.
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [5:0] cfg_dw_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Miscellaneous configuration feature enable.
  input wire logic rev23_features_on_i,
  // Bus events from the interface logic.
  input wire logic int_pending_i,
  input wire logic master_abort_seen_i,
  input wire logic target_abort_rcvd_i,
  input wire logic target_abort_sent_i,
  input wire logic addr_parity_err_i,
  input wire logic data_parity_err_i,
  input wire logic perr_seen_as_master_i,
  // Gates toward the bus interface logic.
  output logic intx_assert_o,
  output logic syserr_drive_o,
  output logic parity_drive_o,
  output logic write_invalidate_ok_o,
  output logic initiator_ok_o,
  output logic mem_claim_ok_o,
  output logic io_claim_ok_o,
  output logic special_claim_ok_o
);
  import pcf_pkg::*;

  // Command storage and its next value.
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  // Live status interrupt bit and event flags.
  logic int_q;
  logic int_d;
  logic [15:0] st_set;
  logic [15:0] st_clr;
  logic [15:0] st_flags;
  logic [15:0] status_word;
  // Read data and registered gates.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [7:0] gates_q;
  logic [7:0] gates_d;
  logic syserr_pulse;
  logic cmd_hit;

  assign cmd_hit = cfg_wr_i && (cfg_dw_i == PCF_DW_CMDSTAT);

  // Command next value: only writable bits, per byte lane.
  always_comb begin
    cmd_d = cmd_q;
    if (cmd_hit) begin
      if (cfg_be_i[0]) begin
        cmd_d[7:0] = cfg_wdata_i[7:0] & PCF_CMD_WMASK[7:0];
      end
      if (cfg_be_i[1]) begin
        cmd_d[15:8] = cfg_wdata_i[15:8] & PCF_CMD_WMASK[15:8];
        cmd_d[PCF_CMD_INTDIS] = cfg_wdata_i[PCF_CMD_INTDIS]
                                & rev23_features_on_i;
      end
    end
    // Interrupt disable is forced clear without revision features.
    if (!rev23_features_on_i) begin
      cmd_d[PCF_CMD_INTDIS] = 1'b0;
    end
  end

  // Command register; every bit resets to zero.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q <= PCF_CMD_RESET;
    end else if (clk_en_i) begin
      cmd_q <= cmd_d;
    end
  end

  // Status interrupt bit follows the source only with revision features on; disable never touches it.
  always_comb begin
    int_d = int_pending_i && rev23_features_on_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_q <= 1'b0;
    end else if (clk_en_i) begin
      int_q <= int_d;
    end
  end

  // System error is signalled only through an enabled driver.
  assign syserr_pulse = addr_parity_err_i && cmd_q[PCF_CMD_SERR];

  // Event set terms for every sticky status bit.
  always_comb begin
    st_set = 16'h0000;
    st_set[PCF_ST_PARERR] = addr_parity_err_i || data_parity_err_i;
    st_set[PCF_ST_SYSERR] = syserr_pulse;
    st_set[PCF_ST_MASTER_ABORT_SEEN] = master_abort_seen_i;
    st_set[PCF_ST_TABORT_REC] = target_abort_rcvd_i;
    st_set[PCF_ST_TABORT_SIG] = target_abort_sent_i;
    st_set[PCF_ST_DATAPAR] = perr_seen_as_master_i && cmd_q[PCF_CMD_PERR];
  end

  // Clear terms from writes of one to the upper status half.
  always_comb begin
    st_clr = 16'h0000;
    if (cmd_hit) begin
      if (cfg_be_i[2]) begin
        st_clr[7:0] = cfg_wdata_i[23:16] & PCF_ST_W1C[7:0];
      end
      if (cfg_be_i[3]) begin
        st_clr[15:8] = cfg_wdata_i[31:24] & PCF_ST_W1C[15:8];
      end
    end
  end

  // One sticky flag per event bit.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (PCF_ST_W1C[gi]) begin : g_on
        pcf_sticky_bit u_flag (
          .sys_clk_i(sys_clk_i),
          .rst_b_i(rst_b_i),
          .clk_en_i(clk_en_i),
          .set_i(st_set[gi]),
          .clr_i(st_clr[gi]),
          .flag_o(st_flags[gi])
        );
      end else begin : g_off
        assign st_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // Status word: fixed bits, live interrupt bit and sticky events.
  always_comb begin
    status_word = PCF_ST_FIXED | st_flags;
    status_word[PCF_ST_INT] = int_q;
  end

  // Read data mux by dword index; unmapped dwords read zero.
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (cfg_rd_i) begin
      rvalid_d = 1'b1;
      if (cfg_dw_i == PCF_DW_IDENT) begin
        rdata_d = {PCF_PART_IDENT, PCF_MAKER_IDENT};
      end else if (cfg_dw_i == PCF_DW_CMDSTAT) begin
        rdata_d = {status_word, cmd_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else if (clk_en_i) begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Gates toward the bus logic, computed from the next command value.
  always_comb begin
    gates_d[0] = int_d && !cmd_d[PCF_CMD_INTDIS];
    gates_d[1] = cmd_d[PCF_CMD_SERR];
    gates_d[2] = cmd_d[PCF_CMD_PERR];
    gates_d[3] = cmd_d[PCF_CMD_MWI];
    gates_d[4] = cmd_d[PCF_CMD_MASTER];
    gates_d[5] = cmd_d[PCF_CMD_MEM];
    gates_d[6] = 1'b0;
    gates_d[7] = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gates_q <= 8'h00;
    end else if (clk_en_i) begin
      gates_q <= gates_d;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign intx_assert_o = gates_q[0];
  assign syserr_drive_o = gates_q[1];
  assign parity_drive_o = gates_q[2];
  assign write_invalidate_ok_o = gates_q[3];
  assign initiator_ok_o = gates_q[4];
  assign mem_claim_ok_o = gates_q[5];
  assign io_claim_ok_o = gates_q[6];
  assign special_claim_ok_o = gates_q[7];

  // Assertions on the visible behaviour.
  property p_ident;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && cfg_rd_i && cfg_dw_i == 6'h00 |=>
      cfg_rvalid_o && cfg_rdata_o == {PCF_PART_IDENT, PCF_MAKER_IDENT};
  endproperty
  a_ident: assert property (p_ident)
    else $error("Bad ident.");

  property p_cmd_zero;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (cmd_q & ~PCF_CMD_WMASK & ~16'h0400) == 16'h0000;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("Fixed bit set.");

  property p_intdis_gate;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !rev23_features_on_i && clk_en_i |=> !cmd_q[PCF_CMD_INTDIS];
  endproperty
  a_intdis_gate: assert property (p_intdis_gate)
    else $error("Disable.");

  property p_intx;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    intx_assert_o |-> int_q && !cmd_q[PCF_CMD_INTDIS];
  endproperty
  a_intx: assert property (p_intx)
    else $error("INTx while blocked.");

  property p_mem;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    mem_claim_ok_o == cmd_q[PCF_CMD_MEM];
  endproperty
  a_mem: assert property (p_mem)
    else $error("Memory gate wrong.");

  property p_master;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    initiator_ok_o == cmd_q[PCF_CMD_MASTER] && !io_claim_ok_o;
  endproperty
  a_master: assert property (p_master)
    else $error("Master gate.");

  // The fixed status bits must reach the read data path, not just exist.
  property p_speed;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && cfg_rd_i && cfg_dw_i == PCF_DW_CMDSTAT |=>
      cfg_rdata_o[26:25] == 2'b01 && cfg_rdata_o[20];
  endproperty
  a_speed: assert property (p_speed)
    else $error("Fixed status.");

  property p_master_abort_seen;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && master_abort_seen_i |=> status_word[PCF_ST_MASTER_ABORT_SEEN];
  endproperty
  a_master_abort_seen: assert property (p_master_abort_seen)
    else $error("Abort lost.");

  property p_w1c;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && cmd_hit && cfg_be_i[3] && cfg_wdata_i[29]
      && !master_abort_seen_i |=> !status_word[PCF_ST_MASTER_ABORT_SEEN];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("Clear failed.");

  // Hardwired command bits 9, 7, 5, 3 and 0 always read back as zero.
  property p_ro_bits;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && cfg_rd_i && cfg_dw_i == PCF_DW_CMDSTAT |=>
      (cfg_rdata_o[15:0] & 16'h02a9) == 16'h0000;
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("Hardwired command bit read as one.");

  // Error drivers follow their enable bits.
  property p_serr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    syserr_drive_o == cmd_q[PCF_CMD_SERR]
      && parity_drive_o == cmd_q[PCF_CMD_PERR];
  endproperty
  a_serr: assert property (p_serr)
    else $error("Error driver gate wrong.");

  property p_mwi;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    write_invalidate_ok_o == cmd_q[PCF_CMD_MWI];
  endproperty
  a_mwi: assert property (p_mwi)
    else $error("Write-invalidate gate wrong.");

  // Without the revision features the interrupt status reads zero.
  property p_int_status;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !rev23_features_on_i && clk_en_i |=> !status_word[PCF_ST_INT];
  endproperty
  a_int_status: assert property (p_int_status)
    else $error("Interrupt status without features.");

  // An address parity error with the driver on records a system error.
  property p_syserr_set;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    clk_en_i && addr_parity_err_i && cmd_q[PCF_CMD_SERR]
      |=> status_word[PCF_ST_SYSERR];
  endproperty
  a_syserr_set: assert property (p_syserr_set)
    else $error("System error not recorded.");

  // Main scenarios: events, interrupts, memory claims and clearing.
  c_master_abort_seen: cover property (@(posedge sys_clk_i) master_abort_seen_i);
  c_intx: cover property (@(posedge sys_clk_i) intx_assert_o);
  c_mem: cover property (@(posedge sys_clk_i) mem_claim_ok_o);
  c_w1c: cover property (@(posedge sys_clk_i) cmd_hit && cfg_be_i[3]);
endmodule : pcf_config_front
`default_nettype wire

// ### pcf_host_model.sv
// Host bridge model: issues configuration reads and writes one at a time.
// Assumes one clock; requests launch 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pcf_host_model (
  // Clock and read answer.
  input wire logic sys_clk_i,
  input wire logic cfg_rvalid_i,
  input wire logic [31:0] cfg_rdata_i,
  // Request lines.
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [5:0] cfg_dw_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o
);
  // Idle lines; unused data carries the inverse of its last value.
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_dw_o = 6'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h00000000;
  end
  // One write, held over exactly one taking edge.
  task automatic wr(input logic [5:0] dw, input logic [3:0] be,
                    input logic [31:0] d);
    cfg_wr_o = 1'b1;
    cfg_dw_o = dw;
    cfg_be_o = be;
    cfg_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~d;
    // One idle edge, so a following write never re-raises the strobe
    // in the time step in which this one lowered it.
    @(posedge sys_clk_i);
    #1;
  endtask : wr
  // One read; the answer is awaited for at most four edges.
  task automatic rd(input logic [5:0] dw, output logic [31:0] q,
                    output logic ok);
    int n;
    cfg_rd_o = 1'b1;
    cfg_dw_o = dw;
    @(posedge sys_clk_i);
    #1;
    cfg_rd_o = 1'b0;
    ok = 1'b0;
    q = 32'h00000000;
    n = 0;
    while (!ok && n < 4) begin
      @(posedge sys_clk_i);
      n++;
      if (cfg_rvalid_i === 1'b1) begin
        q = cfg_rdata_i;
        ok = 1'b1;
      end
    end
    #1;
  endtask : rd
endmodule : pcf_host_model
`default_nettype wire

// ### test_pci_config_header_front.sv
// Testbench for the configuration header front, with a reference model.
// Assumes the host model and a 100 MHz clock; inputs change 1 ns after edges.
`timescale 1ns/1ns
`default_nettype none
module test_pci_config_header_front;
  import pcf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rev23 = 1'b0;
  logic clk_en = 1'b1;
  logic int_pend = 1'b0;
  logic [5:0] ev = 6'h00;
  logic rd, wr, rvalid, intx, serr, perr, mwi, mst, mem, io, spc;
  logic [5:0] dw;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  int fails = 0;
  int compares = 0;
  int m_cmd = 0;
  int m_ev = 0;
  int i, p, x;
  // Clock of 10 ns period.
  always #5 sys_clk_i = ~sys_clk_i;
  pcf_config_front u_pcf_config_front (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .clk_en_i(clk_en), .cfg_rd_i(rd), .cfg_wr_i(wr),
    .cfg_dw_i(dw), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .rev23_features_on_i(rev23), .int_pending_i(int_pend),
    .master_abort_seen_i(ev[0]), .target_abort_rcvd_i(ev[1]),
    .target_abort_sent_i(ev[2]), .addr_parity_err_i(ev[3]),
    .data_parity_err_i(ev[4]), .perr_seen_as_master_i(ev[5]),
    .intx_assert_o(intx), .syserr_drive_o(serr), .parity_drive_o(perr),
    .write_invalidate_ok_o(mwi), .initiator_ok_o(mst),
    .mem_claim_ok_o(mem), .io_claim_ok_o(io), .special_claim_ok_o(spc));
  pcf_host_model u_pcf_host_model (.sys_clk_i(sys_clk_i),
    .cfg_rvalid_i(rvalid), .cfg_rdata_i(rdata), .cfg_rd_o(rd),
    .cfg_wr_o(wr), .cfg_dw_o(dw), .cfg_be_o(be), .cfg_wdata_o(wdata));
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Compares one value and reports a mismatch.
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Expected status word from the model.
  function automatic logic [15:0] m_st();
    return 16'(m_ev | 'h0210 | (int'(int_pend & rev23) << 3));
  endfunction : m_st
  // Write through the host and update the model.
  task automatic cw(int d, logic [3:0] b, logic [31:0] v);
    int wm;
    wm = 'h0156 | (rev23 ? 'h0400 : 0);
    u_pcf_host_model.wr(6'(d), b, v);
    for (int k = 0; k < 2 && d == 1; k++) begin
      if (b[k]) m_cmd = (m_cmd & ~(wm & ('hff << 8*k))) |
                        (v & wm & ('hff << 8*k));
      if (b[k+2]) m_ev = m_ev & ~((v >> 16) & ('hff << 8*k));
    end
  endtask : cw
  // Read one dword and compare.
  task automatic cr(int d, logic [31:0] e, string n);
    logic [31:0] q;
    logic ok;
    u_pcf_host_model.rd(6'(d), q, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value %s_rvalid expected 1 seen 0", n);
      end_sim();
    end else begin
      chk(n, e, q);
    end
  endtask : cr
  // Gates follow the command bits; io and special never claim.
  task automatic gates();
    chk("gates", {25'h0, m_cmd[8], m_cmd[6], m_cmd[4], m_cmd[2], m_cmd[1],
        2'b00}, {25'h0, serr, perr, mwi, mst, mem, io, spc});
  endtask : gates
  // Status bits set by each event, given the command.
  function automatic int ev_bits(int k);
    case (k)
      0: return 'h2000;
      1: return 'h1000;
      2: return 'h0800;
      3: return 'h8000 | (m_cmd[8] ? 'h4000 : 0);
      4: return 'h8000;
      default: return 'h8000 | (m_cmd[6] ? 'h0100 : 0);
    endcase
  endfunction : ev_bits
  initial begin
    x = $urandom(96004);
    repeat (20) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    cr(0, {PCF_PART_IDENT, PCF_MAKER_IDENT}, "ident");
    cr(1, 32'h02100000, "reset");
    gates();
    cw(0, 4'hf, 32'hffffffff);
    cr(0, {PCF_PART_IDENT, PCF_MAKER_IDENT}, "ident_wr");
    cr(5, 32'h0, "unmapped");
    cw(1, 4'h3, 32'h0000ffff);
    cr(1, {m_st(), m_cmd[15:0]}, "cmd_norev");
    gates();
    rev23 = 1'b1;
    int_pend = 1'b1;
    cw(1, 4'h3, 32'h0000ffff);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("intx_off", 32'h0, {31'h0, intx});
    cr(1, {m_st(), m_cmd[15:0]}, "cmd_rev");
    cw(1, 4'h3, 32'h00000000);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("intx_on", 32'h1, {31'h0, intx});
    int_pend = 1'b0;
    // Events in both command settings, then clearing by writing ones.
    for (p = 0; p < 2; p++) begin
      cw(1, 4'h3, p ? 32'h0 : 32'h0156);
      for (i = 0; i < 6; i++) begin
        ev[i] = 1'b1;
        ev[4] = ev[4] | (i == 5);
        @(posedge sys_clk_i);
        #1;
        ev = 6'h00;
        m_ev = m_ev | ev_bits(i);
        cr(1, {m_st(), m_cmd[15:0]}, "event");
        cw(1, 4'hc, 32'h0);
        cr(1, {m_st(), m_cmd[15:0]}, "zero_keeps");
      end
      cw(1, 4'hc, 32'hffff0000);
      cr(1, {m_st(), m_cmd[15:0]}, "w1c");
    end
    // An abort in the very cycle of its clear keeps the flag set.
    ev[0] = 1'b1;
    ev[0] <= #10 1'b0;
    cw(1, 4'h8, 32'h20000000);
    m_ev = m_ev | 'h2000;
    cr(1, {m_st(), m_cmd[15:0]}, "set_wins");
    // A write while the clock enable is low changes nothing.
    clk_en = 1'b0;
    u_pcf_host_model.wr(6'h01, 4'hf, 32'hffffffff);
    clk_en = 1'b1;
    cr(1, {m_st(), m_cmd[15:0]}, "frozen");
    gates();
    // Random command and status writes with random byte enables.
    for (i = 0; i < 12; i++) begin
      rev23 = i[0];
      if (!rev23) m_cmd = m_cmd & 'hfbff;
      cw(1, 4'($urandom()), $urandom());
      cr(1, {m_st(), m_cmd[15:0]}, "random");
      gates();
      cw(1, 4'h3, 32'h0);
    end
    // A reset in mid-run returns every register to its reset value.
    rst_b_i = 1'b0;
    m_cmd = 0;
    m_ev = 0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    cr(1, {m_st(), m_cmd[15:0]}, "reset_mid");
    gates();
    end_sim();
  end
endmodule : test_pci_config_header_front
`default_nettype wire
